// ### rtl/lfis_pkg.sv
// Constants for the latched fault and interrupt status block.
package lfis_pkg;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] EVENT_SUPPRESS_PRIMARY_OFS = 8'h2f;
    localparam logic [7:0] FAULT_SUPPRESS_OFS         = 8'h32;
    localparam logic [7:0] EVENT_LATCH_PRIMARY_OFS    = 8'h34;
    localparam logic [7:0] OUTPUT1_FAULT_LATCH_OFS    = 8'h38;
    localparam logic [7:0] OUTPUT2_FAULT_LATCH_OFS    = 8'h39;
    localparam logic [7:0] HEADSET_EVENT_LATCH_OFS    = 8'h3a;
    localparam logic [7:0] EVENT_PRESENT_PRIMARY_OFS  = 8'h3c;
    localparam logic [7:0] OUTPUT1_FAULT_PRESENT_OFS  = 8'h40;
    localparam logic [7:0] OUTPUT2_FAULT_PRESENT_OFS  = 8'h41;
    localparam logic [7:0] HEADSET_EVENT_PRESENT_OFS  = 8'h42;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [1:0] EVENT_SUPPRESS_RST = 2'h3;
    localparam logic [4:0] FAULT_SUPPRESS_RST = 5'h00;
    localparam logic [7:0] REG_ZERO           = 8'h00;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CLK_ERR_BIT    = 7;
    localparam int PLL_LOCK_BIT   = 6;
    localparam int POS_SHORT_BIT  = 7;
    localparam int NEG_SHORT_BIT  = 6;
    localparam int POS_VGND_BIT   = 5;
    localparam int NEG_VGND_BIT   = 4;
    localparam int ADC1_SUPP_BIT  = 3;
    localparam int ADC2_SUPP_BIT  = 2;
    localparam int REG_SUPP_BIT   = 1;
    localparam int REG_SHORT_BIT  = 0;
    localparam int HS_INSERT_BIT  = 3;
    localparam int HS_REMOVE_BIT  = 2;
    localparam int HS_HOOK_BIT    = 1;
    localparam int OUT_SHORT_MBIT = 5;
    localparam int OUT_VGND_MBIT  = 4;

    // ----------------------------------------------------------------
    // Cause indices
    // ----------------------------------------------------------------
    localparam int NCAUSE    = 14;
    localparam int C_CLK_ERR = 0;
    localparam int C_PLL     = 1;
    localparam int C_O1P_SC  = 2;
    localparam int C_O1M_SC  = 3;
    localparam int C_O1P_VG  = 4;
    localparam int C_O1M_VG  = 5;
    localparam int C_O2P_SC  = 6;
    localparam int C_O2M_SC  = 7;
    localparam int C_O2P_VG  = 8;
    localparam int C_O2M_VG  = 9;
    localparam int C_REG_SC  = 10;
    localparam int C_HS_INS  = 11;
    localparam int C_HS_REM  = 12;
    localparam int C_HS_HOOK = 13;

endpackage

// ### rtl/lfis_latch_if.sv
// Interface between the status top and its sticky flag bank.
`timescale 1ns/1ps
interface lfis_latch_if
    import lfis_pkg::*;
();
    logic [NCAUSE-1:0] evt;
    logic [NCAUSE-1:0] clr;
    logic [NCAUSE-1:0] flag;

    modport owner (output evt, output clr, input flag);
    modport bank  (input evt, input clr, output flag);
endinterface

// ### rtl/lfis_sticky_bank.sv
// Bank of sticky cause flags, one flip-flop per cause.
`timescale 1ns/1ps
module lfis_sticky_bank
    import lfis_pkg::*;
(
    // Clock and reset
    input wire logic   clk,
    input wire logic   sys_rst,
    // Flag traffic
    lfis_latch_if.bank lat
);

    // ----------------------------------------------------------------
    // Sticky flags
    // ----------------------------------------------------------------
    for (genvar gi = 0; gi < NCAUSE; gi++)
    begin : g_flag
        logic flag_ff;
        always_ff @(posedge clk or posedge sys_rst)
        begin
            if (sys_rst)
                flag_ff <= 1'b0;
            else if (lat.evt[gi])
                flag_ff <= 1'b1;
            else if (lat.clr[gi])
                flag_ff <= 1'b0;
        end
        assign lat.flag[gi] = flag_ff;
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    setWinsClear_a: assert property (lat.evt[0] && lat.clr[0] |=> lat.flag[0])
        else $error("Event coinciding with clear was lost.");
    clearOnRead_a: assert property (!lat.evt[C_O1P_SC] && lat.clr[C_O1P_SC]
                                    |=> !lat.flag[C_O1P_SC])
        else $error("Flag survived a clear with no event.");

endmodule

// ### rtl/lfis_top.sv
// Latched fault and interrupt status registers with live readback and request.
`timescale 1ns/1ps
module lfis_top
    import lfis_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              sys_rst,
    // Detector levels
    input  wire logic [NCAUSE-1:0] causeRaw,
    // Register port
    input  wire logic [7:0]        regAddr,
    input  wire logic              regWrEn,
    input  wire logic [7:0]        regWrData,
    input  wire logic              regRdEn,
    output logic      [7:0]        regRdData,
    output logic                   regRdValid,
    // Outputs to the rest of the device
    output logic                   irqReq,
    output logic                   adc1OverloadSuppress,
    output logic                   adc2OverloadSuppress
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [NCAUSE-1:0] causeMeta_ff;
    logic [NCAUSE-1:0] causeSync_ff;
    logic [1:0]        eventSuppress_ff;
    logic [4:0]        faultSuppress_ff;
    logic              adc1Suppress_ff;
    logic              adc2Suppress_ff;
    logic              regSuppress_ff;
    logic [7:0]        regRdData_ff;
    logic [7:0]        nxt_regRdData;
    logic              regRdValid_ff;
    logic              irqReq_ff;
    logic [NCAUSE-1:0] maskVec;
    logic [NCAUSE-1:0] clrVec;
    logic [NCAUSE-1:0] flagVec;
    logic              rdStrobe;

    lfis_latch_if lat ();

    // ----------------------------------------------------------------
    // Detector synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            causeMeta_ff <= '0;
            causeSync_ff <= '0;
        end
        else
        begin
            causeMeta_ff <= causeRaw;
            causeSync_ff <= causeMeta_ff;
        end
    end

    // ----------------------------------------------------------------
    // Sticky flags and read clears
    // ----------------------------------------------------------------
    assign rdStrobe = regRdEn && !regWrEn;

    always_comb
    begin
        clrVec = '0;
        if (rdStrobe)
        begin
            case (regAddr)
                EVENT_LATCH_PRIMARY_OFS: clrVec[C_PLL:C_CLK_ERR]   = '1;
                OUTPUT1_FAULT_LATCH_OFS: clrVec[C_O1M_VG:C_O1P_SC] = '1;
                OUTPUT2_FAULT_LATCH_OFS: clrVec[C_REG_SC:C_O2P_SC] = '1;
                HEADSET_EVENT_LATCH_OFS: clrVec[C_HS_HOOK:C_HS_INS] = '1;
                default:                 clrVec = '0;
            endcase
        end
    end

    assign lat.evt = causeSync_ff;
    assign lat.clr = clrVec;
    assign flagVec = lat.flag;

    lfis_sticky_bank u_bank (
        .clk     (clk),
        .sys_rst (sys_rst),
        .lat     (lat)
    );

    // ----------------------------------------------------------------
    // Writable suppress bits
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            eventSuppress_ff <= EVENT_SUPPRESS_RST;
            faultSuppress_ff <= FAULT_SUPPRESS_RST;
            adc1Suppress_ff  <= 1'b0;
            adc2Suppress_ff  <= 1'b0;
            regSuppress_ff   <= 1'b0;
        end
        else if (regWrEn)
        begin
            case (regAddr)
                EVENT_SUPPRESS_PRIMARY_OFS:
                    eventSuppress_ff <= regWrData[CLK_ERR_BIT:PLL_LOCK_BIT];
                FAULT_SUPPRESS_OFS:
                    faultSuppress_ff <= regWrData[OUT_SHORT_MBIT:HS_HOOK_BIT];
                OUTPUT1_FAULT_LATCH_OFS:
                begin
                    adc1Suppress_ff <= regWrData[ADC1_SUPP_BIT];
                    adc2Suppress_ff <= regWrData[ADC2_SUPP_BIT];
                end
                OUTPUT2_FAULT_LATCH_OFS:
                    regSuppress_ff <= regWrData[REG_SUPP_BIT];
                default:
                    regSuppress_ff <= regSuppress_ff;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    always_comb
    begin
        nxt_regRdData = REG_ZERO;
        case (regAddr)
            EVENT_SUPPRESS_PRIMARY_OFS:
                nxt_regRdData[CLK_ERR_BIT:PLL_LOCK_BIT] = eventSuppress_ff;
            FAULT_SUPPRESS_OFS:
                nxt_regRdData[OUT_SHORT_MBIT:HS_HOOK_BIT] = faultSuppress_ff;
            EVENT_LATCH_PRIMARY_OFS:
            begin
                nxt_regRdData[CLK_ERR_BIT]  = flagVec[C_CLK_ERR];
                nxt_regRdData[PLL_LOCK_BIT] = flagVec[C_PLL];
            end
            OUTPUT1_FAULT_LATCH_OFS:
            begin
                nxt_regRdData[POS_SHORT_BIT:NEG_VGND_BIT] = {flagVec[C_O1P_SC],
                    flagVec[C_O1M_SC], flagVec[C_O1P_VG], flagVec[C_O1M_VG]};
                nxt_regRdData[ADC1_SUPP_BIT] = adc1Suppress_ff;
                nxt_regRdData[ADC2_SUPP_BIT] = adc2Suppress_ff;
            end
            OUTPUT2_FAULT_LATCH_OFS:
            begin
                nxt_regRdData[POS_SHORT_BIT:NEG_VGND_BIT] = {flagVec[C_O2P_SC],
                    flagVec[C_O2M_SC], flagVec[C_O2P_VG], flagVec[C_O2M_VG]};
                nxt_regRdData[REG_SUPP_BIT]  = regSuppress_ff;
                nxt_regRdData[REG_SHORT_BIT] = flagVec[C_REG_SC];
            end
            HEADSET_EVENT_LATCH_OFS:
            begin
                nxt_regRdData[HS_INSERT_BIT] = flagVec[C_HS_INS];
                nxt_regRdData[HS_REMOVE_BIT] = flagVec[C_HS_REM];
                nxt_regRdData[HS_HOOK_BIT]   = flagVec[C_HS_HOOK];
            end
            EVENT_PRESENT_PRIMARY_OFS:
            begin
                nxt_regRdData[CLK_ERR_BIT]  = causeSync_ff[C_CLK_ERR];
                nxt_regRdData[PLL_LOCK_BIT] = causeSync_ff[C_PLL];
            end
            OUTPUT1_FAULT_PRESENT_OFS:
                nxt_regRdData[POS_SHORT_BIT:NEG_VGND_BIT] = {causeSync_ff[C_O1P_SC],
                    causeSync_ff[C_O1M_SC], causeSync_ff[C_O1P_VG], causeSync_ff[C_O1M_VG]};
            OUTPUT2_FAULT_PRESENT_OFS:
            begin
                nxt_regRdData[POS_SHORT_BIT:NEG_VGND_BIT] = {causeSync_ff[C_O2P_SC],
                    causeSync_ff[C_O2M_SC], causeSync_ff[C_O2P_VG], causeSync_ff[C_O2M_VG]};
                nxt_regRdData[REG_SHORT_BIT] = causeSync_ff[C_REG_SC];
            end
            HEADSET_EVENT_PRESENT_OFS:
            begin
                nxt_regRdData[HS_INSERT_BIT] = causeSync_ff[C_HS_INS];
                nxt_regRdData[HS_REMOVE_BIT] = causeSync_ff[C_HS_REM];
                nxt_regRdData[HS_HOOK_BIT]   = causeSync_ff[C_HS_HOOK];
            end
            default:
                nxt_regRdData = REG_ZERO;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            regRdData_ff  <= REG_ZERO;
            regRdValid_ff <= 1'b0;
        end
        else
        begin
            regRdValid_ff <= rdStrobe;
            if (rdStrobe)
                regRdData_ff <= nxt_regRdData;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt request
    // ----------------------------------------------------------------
    always_comb
    begin
        maskVec            = '0;
        maskVec[C_CLK_ERR] = eventSuppress_ff[1];
        maskVec[C_PLL]     = eventSuppress_ff[0];
        maskVec[C_O1P_SC]  = faultSuppress_ff[4];
        maskVec[C_O1M_SC]  = faultSuppress_ff[4];
        maskVec[C_O2P_SC]  = faultSuppress_ff[4];
        maskVec[C_O2M_SC]  = faultSuppress_ff[4];
        maskVec[C_O1P_VG]  = faultSuppress_ff[3];
        maskVec[C_O1M_VG]  = faultSuppress_ff[3];
        maskVec[C_O2P_VG]  = faultSuppress_ff[3];
        maskVec[C_O2M_VG]  = faultSuppress_ff[3];
        maskVec[C_REG_SC]  = regSuppress_ff;
        maskVec[C_HS_INS]  = faultSuppress_ff[2];
        maskVec[C_HS_REM]  = faultSuppress_ff[1];
        maskVec[C_HS_HOOK] = faultSuppress_ff[0];
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            irqReq_ff <= 1'b0;
        else
            irqReq_ff <= |(flagVec & ~maskVec);
    end

    assign regRdData            = regRdData_ff;
    assign regRdValid           = regRdValid_ff;
    assign irqReq               = irqReq_ff;
    assign adc1OverloadSuppress = adc1Suppress_ff;
    assign adc2OverloadSuppress = adc2Suppress_ff;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence readPrimary;
        rdStrobe && regAddr == EVENT_LATCH_PRIMARY_OFS;
    endsequence

    clkErrLatch_a: assert property (causeSync_ff[C_CLK_ERR] ##1 readPrimary
                                    |=> regRdData_ff[CLK_ERR_BIT])
        else $error("Clock error not latched.");
    pllLatch_a: assert property (causeSync_ff[C_PLL] |=> flagVec[C_PLL])
        else $error("PLL lock event not latched.");
    reservedZero_a: assert property (readPrimary |=> regRdData_ff[5:0] == 6'h00)
        else $error("Reserved bits read nonzero.");
    out1Short_a: assert property (causeSync_ff[C_O1P_SC] ##1
                                  (rdStrobe && regAddr == OUTPUT1_FAULT_LATCH_OFS)
                                  |=> regRdData_ff[POS_SHORT_BIT])
        else $error("Channel 1 short not latched.");
    out1Vgnd_a: assert property (causeSync_ff[C_O1M_VG] |=> flagVec[C_O1M_VG])
        else $error("Channel 1 virtual ground not latched.");
    adcSuppress_a: assert property (regWrEn && regAddr == OUTPUT1_FAULT_LATCH_OFS
                                    |=> adc1OverloadSuppress == $past(regWrData[3])
                                        && adc2OverloadSuppress == $past(regWrData[2]))
        else $error("ADC suppress bits did not take the write.");
    out2Faults_a: assert property ((causeSync_ff[C_O2P_SC] |=> flagVec[C_O2P_SC])
                                   and (causeSync_ff[C_O2M_VG] |=> flagVec[C_O2M_VG]))
        else $error("Channel 2 faults not latched.");
    regShort_a: assert property (causeSync_ff[C_REG_SC] |=> flagVec[C_REG_SC])
        else $error("Regulator short not latched.");
    headset_a: assert property (causeSync_ff[C_HS_HOOK] |=> flagVec[C_HS_HOOK])
        else $error("Hook press not latched.");
    clkErrMasked_a: assert property (eventSuppress_ff[1] && flagVec == 14'h0001
                                     |=> !irqReq_ff)
        else $error("Masked clock error raised the request.");
    livePrimary_a: assert property (rdStrobe && regAddr == EVENT_PRESENT_PRIMARY_OFS
                                    |=> regRdData_ff[CLK_ERR_BIT] == $past(causeSync_ff[0]))
        else $error("Live clock error readback wrong.");
    readClears_a: assert property (readPrimary and !causeSync_ff[C_PLL]
                                   |=> !flagVec[C_PLL])
        else $error("Read did not clear the latched flag.");
    irqFollows_a: assert property (##1 irqReq_ff == $past(|(flagVec & ~maskVec)))
        else $error("Request does not follow unmasked flags.");

endmodule

// ### testbench/lfis_detector_model.sv
// Model of the fault and event detectors that feed the status block.
`timescale 1ns/1ps
module lfis_detector_model
    import lfis_pkg::*;
(
    // Clock
    input  wire logic              clk,
    // Detector levels
    output logic      [NCAUSE-1:0] causeRaw
);
    initial causeRaw = '0;

    // ----------------------------------------------------------------
    // Detector activity
    // ----------------------------------------------------------------
    // Raises one cause for a number of cycles, changing only at falling edges.
    task automatic raise(input int idx, input int len);
        @(negedge clk);
        causeRaw[idx] = 1'b1;
        repeat (len) @(negedge clk);
        causeRaw[idx] = 1'b0;
    endtask

    // Sets one cause to a steady level.
    task automatic hold(input int idx, input logic lvl);
        @(negedge clk);
        causeRaw[idx] = lvl;
    endtask
endmodule

// ### testbench/lfis_top_tb.sv
// Self-checking testbench for the latched fault and interrupt status block.
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) \
        begin \
            mismatches++; \
            $display("Error at %0t: got %h expected %h", $time, got, exp); \
        end \
    end
module lfis_top_tb
    import lfis_pkg::*;
;
    logic              clk;
    logic              sys_rst;
    logic [NCAUSE-1:0] causeRaw;
    logic [7:0]        regAddr;
    logic              regWrEn;
    logic [7:0]        regWrData;
    logic              regRdEn;
    logic [7:0]        regRdData;
    logic              regRdValid;
    logic              irqReq;
    logic              adc1OverloadSuppress;
    logic              adc2OverloadSuppress;
    int                mismatches;
    int                cmp_count;
    int                cycles;
    logic [7:0]        latAddr [NCAUSE];
    int                latBit  [NCAUSE];

    lfis_top DUT (
        .clk                  (clk),
        .sys_rst              (sys_rst),
        .causeRaw             (causeRaw),
        .regAddr              (regAddr),
        .regWrEn              (regWrEn),
        .regWrData            (regWrData),
        .regRdEn              (regRdEn),
        .regRdData            (regRdData),
        .regRdValid           (regRdValid),
        .irqReq               (irqReq),
        .adc1OverloadSuppress (adc1OverloadSuppress),
        .adc2OverloadSuppress (adc2OverloadSuppress)
    );

    lfis_detector_model DET (
        .clk      (clk),
        .causeRaw (causeRaw)
    );

    // ----------------------------------------------------------------
    // Clock, timeout and verdict
    // ----------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            results();
        end
    end

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Register port tasks
    // ----------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        regAddr   = a;
        regWrData = d;
        regWrEn   = 1'b1;
        @(negedge clk);
        regWrEn   = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge clk);
        regRdEn = 1'b0;
        `CHK(regRdValid, 1'b1)
        `CHK(regRdData, exp)
    endtask

    task automatic chk_irq(input logic exp);
        @(negedge clk);
        `CHK(irqReq, exp)
    endtask

    function automatic logic [7:0] live_of(input logic [7:0] a);
        return a == 8'h34 ? 8'h3c : a == 8'h38 ? 8'h40 : a == 8'h39 ? 8'h41 : 8'h42;
    endfunction

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial
    begin
        latAddr = '{8'h34, 8'h34, 8'h38, 8'h38, 8'h38, 8'h38, 8'h39,
                    8'h39, 8'h39, 8'h39, 8'h39, 8'h3a, 8'h3a, 8'h3a};
        latBit  = '{7, 6, 7, 6, 5, 4, 7, 6, 5, 4, 0, 3, 2, 1};
        mismatches = 0;
        cmp_count  = 0;
        cycles     = 0;
        regAddr    = 8'h00;
        regWrEn    = 1'b0;
        regWrData  = 8'h00;
        regRdEn    = 1'b0;
        sys_rst    = 1'b1;
        repeat (16) @(negedge clk);
        sys_rst = 1'b0;
        // Reset values of the four latch registers, the event suppress register and an unmapped address.
        rd(8'h34, 8'h00);
        rd(8'h38, 8'h00);
        rd(8'h39, 8'h00);
        rd(8'h3a, 8'h00);
        rd(8'h2f, 8'hc0);
        rd(8'h50, 8'h00);
        `CHK(irqReq, 1'b0)
        // Writable suppress bits and read-only reserved bits.
        wr(8'h38, 8'hff);
        `CHK({adc1OverloadSuppress, adc2OverloadSuppress}, 2'b11)
        rd(8'h38, 8'h0c);
        wr(8'h38, 8'h04);
        `CHK({adc1OverloadSuppress, adc2OverloadSuppress}, 2'b01)
        wr(8'h39, 8'hff);
        rd(8'h39, 8'h02);
        wr(8'h34, 8'hff);
        rd(8'h34, 8'h00);
        wr(8'h3a, 8'hff);
        rd(8'h3a, 8'h00);
        wr(8'h2f, 8'hff);
        rd(8'h2f, 8'hc0);
        wr(8'h38, 8'h00);
        wr(8'h39, 8'h00);
        // Every cause latches into its own bit and clears on read.
        for (int i = 0; i < NCAUSE; i++)
        begin
            DET.hold(i, 1'b1);
            repeat (4) @(negedge clk);
            rd(live_of(latAddr[i]), 8'h01 << latBit[i]);
            DET.hold(i, 1'b0);
            repeat (6) @(negedge clk);
            `CHK(irqReq, (i >= 2))
            rd(latAddr[i], 8'h01 << latBit[i]);
            rd(latAddr[i], 8'h00);
            rd(live_of(latAddr[i]), 8'h00);
            chk_irq(1'b0);
        end
        // A cause present at the read edge keeps its flag set.
        DET.hold(C_HS_INS, 1'b1);
        repeat (6) @(negedge clk);
        rd(8'h42, 8'h08);
        rd(8'h3a, 8'h08);
        rd(8'h3a, 8'h08);
        DET.hold(C_HS_INS, 1'b0);
        repeat (4) @(negedge clk);
        rd(8'h3a, 8'h08);
        rd(8'h3a, 8'h00);
        // Clock error request gated by its suppress bit.
        DET.raise(C_CLK_ERR, 3);
        repeat (6) @(negedge clk);
        chk_irq(1'b0);
        wr(8'h2f, 8'h40);
        chk_irq(1'b1);
        rd(8'h34, 8'h80);
        chk_irq(1'b0);
        // Regulator short latched while its request is suppressed.
        wr(8'h39, 8'h02);
        DET.raise(C_REG_SC, 3);
        repeat (6) @(negedge clk);
        chk_irq(1'b0);
        rd(8'h39, 8'h03);
        rd(8'h39, 8'h02);
        // Fault suppress register gates the hook press request.
        rd(8'h32, 8'h00);
        wr(8'h32, 8'hff);
        rd(8'h32, 8'h3e);
        DET.raise(C_HS_HOOK, 3);
        repeat (6) @(negedge clk);
        chk_irq(1'b0);
        wr(8'h32, 8'h00);
        chk_irq(1'b1);
        rd(8'h3a, 8'h02);
        chk_irq(1'b0);
        results();
    end
endmodule
